//--- sped_regs.svh
`ifndef SPED_REGS_SVH
`define SPED_REGS_SVH
// Overview of operation
// - entry shows edit prompt on row 8
// - next-line closes, numbers line, advances prompt
// - mnemonics spaced, except between adjacent numerics
// - overflow past 35 wraps line, silent warning
// - execute returns idle, restores crt display
// - one key alternates program entry and execute
// - run from line zero, busy lit throughout
// - stored stop shows line number, row 16
// - erase-all needs next-line confirmation, prompt shown
// - any other following command aborts erase
// - erase-all in idle is an error; ignored while running
// - labels 00 to 99, one hundred routines
// - label lookup takes first line only
// - program memory holds up to 1000 lines
// - first programmable command starts entry mode
// - run/step accept only direct stop
// - compare false skips to next line
`define PROMPT_ROW   5'h0_8
`define HALT_ROW     5'h1_0
`define LINE_LIMIT   6'h2_3
`define MAX_LINES    10'h3_E8
`define NUM_LABELS   7'h6_4
`define CMD_DEPTH    1024
`define CMD_LAST     10'h3_FF
`endif

//--- sped_pkg.sv
package sped_pkg;
  typedef enum logic [3:0] {
    K_PROGRAM_ENTRY_COMMAND, K_EXECUTE, K_NEXT, K_ERASE_ALL, K_ERASE_LINE, K_STOP,
    K_RUN, K_STEP, K_LABEL, K_COMPARE, K_OTHER
  } kind_e;
  typedef enum logic [1:0] {M_IDLE, M_ENTRY, M_EDIT, M_RUN} mode_e;
  // one keystroke command from keyboard or bus
  typedef struct packed {
    logic       valid;
    kind_e      kind;
    logic       numeric;
    logic [5:0] len;
    logic [7:0] code;
    logic [6:0] label;
  } cmd_s;
  // stored command: everything but the strobe
  typedef struct packed {
    kind_e      kind;
    logic       numeric;
    logic [5:0] len;
    logic [7:0] code;
    logic [6:0] label;
  } stored_s;
endpackage

//--- stored_program_entry_editor.sv
`timescale 1ns/1ps
`include "sped_regs.svh"
module stored_program_entry_editor (
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               arst_n_i,
  // commands
  input  wire sped_pkg::cmd_s     cmd_i,
  input  wire logic               key_i,
  input  wire logic               yx_greater_i,
  input  wire logic [3:0]         crt_mode_i,
  // label lookup
  input  wire logic [6:0]         label_query_i,
  output logic                    label_found_o,
  output logic [9:0]              label_line_o,
  // display
  output sped_pkg::mode_e         mode_o,
  output logic                    program_display_o,
  output logic [3:0]              display_mode_o,
  output logic [4:0]              prompt_row_o,
  output logic                    show_line_number_o,
  output logic [9:0]              cur_line_o,
  output logic [9:0]              line_count_o,
  output logic [5:0]              line_chars_o,
  output logic                    confirm_prompt_o,
  output logic                    warning_o,
  output logic                    clear_error_o,
  // execution
  output logic                    busy_o,
  output logic                    exec_valid_o,
  output sped_pkg::stored_s       exec_cmd_o,
  output logic                    halt_shown_o,
  output logic [9:0]              halt_line_o,
  output logic [4:0]              halt_row_o
);
  sped_pkg::stored_s   mem_ff [`CMD_DEPTH];
  logic                eol_ff [`CMD_DEPTH];
  logic [9:0]          lbl_line_ff [100];
  logic [99:0]         lbl_vld_ff;

  sped_pkg::mode_e     mode_ff;
  logic [9:0]          wr_ptr_ff;
  logic [9:0]          lines_ff;
  logic [9:0]          cur_line_ff;
  logic [5:0]          chars_ff;
  logic                prev_num_ff;
  logic                confirm_ff;
  logic                warning_ff;
  logic                clr_err_ff;
  logic [9:0]          pc_ff;
  logic [9:0]          exec_line_ff;
  logic                skip_ff;
  logic                step_ff;
  logic                exec_valid_ff;
  sped_pkg::stored_s   exec_cmd_ff;
  logic                halt_shown_ff;
  logic [9:0]          halt_line_ff;

  // key alternates by mode, so it can never fall out of step with it
  wire                 in_program_entry_command   = (mode_ff == sped_pkg::M_ENTRY) || (mode_ff == sped_pkg::M_EDIT);
  wire sped_pkg::kind_e key_kind = in_program_entry_command ? sped_pkg::K_EXECUTE : sped_pkg::K_PROGRAM_ENTRY_COMMAND;
  wire                 c_vld     = cmd_i.valid | key_i;
  wire sped_pkg::kind_e c_kind   = key_i ? key_kind : cmd_i.kind;
  wire sped_pkg::stored_s c_st   = '{kind: c_kind, numeric: cmd_i.numeric, len: cmd_i.len,
                                     code: cmd_i.code, label: cmd_i.label};

  wire is_program_entry_command   = c_vld && (c_kind == sped_pkg::K_PROGRAM_ENTRY_COMMAND);
  wire is_exec   = c_vld && (c_kind == sped_pkg::K_EXECUTE);
  wire is_next   = c_vld && (c_kind == sped_pkg::K_NEXT);
  wire is_erase  = c_vld && (c_kind == sped_pkg::K_ERASE_ALL);
  wire is_eline  = c_vld && (c_kind == sped_pkg::K_ERASE_LINE);
  wire is_stop   = c_vld && (c_kind == sped_pkg::K_STOP);
  wire is_run    = c_vld && ((c_kind == sped_pkg::K_RUN) || (c_kind == sped_pkg::K_STEP));
  wire is_progbl = c_vld && ((c_kind == sped_pkg::K_STOP) || (c_kind == sped_pkg::K_LABEL) ||
                             (c_kind == sped_pkg::K_COMPARE) || (c_kind == sped_pkg::K_OTHER) ||
                             (c_kind == sped_pkg::K_RUN) || (c_kind == sped_pkg::K_STEP));

  // space between neighbours unless both are numeric
  wire       need_space = (chars_ff != 6'h0_0) && !(prev_num_ff && cmd_i.numeric);
  wire [6:0] add_total  = {1'b0, chars_ff} + {1'b0, cmd_i.len} + {6'h0_0, need_space};
  wire       overflow   = (chars_ff != 6'h0_0) && (add_total > {1'b0, `LINE_LIMIT});
  // a wrap or a store of a first command opens a new line; full memory refuses it
  wire       opens_line = (chars_ff == 6'h0_0) || overflow;
  wire       full       = (wr_ptr_ff == `CMD_LAST) ||
                          (opens_line && (lines_ff == `MAX_LINES));
  wire       store      = !confirm_ff && in_program_entry_command && is_progbl && !full;
  wire       close_line = !confirm_ff && (mode_ff == sped_pkg::M_ENTRY) &&
                          (chars_ff != 6'h0_0) && (is_next || is_exec || is_eline ||
                          is_erase || is_program_entry_command);
  wire [9:0] line_num   = overflow ? (lines_ff + 10'h0_01) : lines_ff;
  wire       wipe       = confirm_ff && is_next;
  wire       lbl_new    = store && (c_kind == sped_pkg::K_LABEL) &&
                          (cmd_i.label < `NUM_LABELS) && !lbl_vld_ff[cmd_i.label];

  // execution side
  wire sped_pkg::stored_s rd = mem_ff[pc_ff];
  wire       run_state  = (mode_ff == sped_pkg::M_RUN);
  wire       at_end     = (pc_ff == wr_ptr_ff);
  wire       rd_stop    = run_state && !at_end && !skip_ff && (rd.kind == sped_pkg::K_STOP);
  wire       cmp_false  = run_state && !at_end && !skip_ff &&
                          (rd.kind == sped_pkg::K_COMPARE) && !yx_greater_i;
  wire       halt_now   = run_state && (is_stop || rd_stop || at_end ||
                          (step_ff && !skip_ff));

  wire [5:0] nxt_chars  = overflow ? cmd_i.len : add_total[5:0];

  always_ff @(posedge clock_i)
  begin
    if (store)
    begin
      mem_ff[wr_ptr_ff] <= c_st;
      eol_ff[wr_ptr_ff] <= 1'b0;
      if (overflow)
        eol_ff[wr_ptr_ff - 10'h0_01] <= 1'b1;
    end
    else if (close_line)
      eol_ff[wr_ptr_ff - 10'h0_01] <= 1'b1;
    if (lbl_new)
      lbl_line_ff[cmd_i.label] <= (chars_ff == 6'h0_0) ? lines_ff : line_num;
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mode_ff     <= sped_pkg::M_IDLE;
      wr_ptr_ff   <= 10'h0_00;
      lines_ff    <= 10'h0_00;
      cur_line_ff <= 10'h0_00;
      chars_ff    <= 6'h0_0;
      prev_num_ff <= 1'b0;
      confirm_ff  <= 1'b0;
      warning_ff  <= 1'b0;
      clr_err_ff  <= 1'b0;
      lbl_vld_ff  <= '0;
    end
    else
    begin
      warning_ff <= store && overflow;
      clr_err_ff <= is_erase && !in_program_entry_command && !run_state;
      if (lbl_new)
        lbl_vld_ff[cmd_i.label] <= 1'b1;
      if (store)
      begin
        wr_ptr_ff   <= wr_ptr_ff + 10'h0_01;
        chars_ff    <= nxt_chars;
        prev_num_ff <= cmd_i.numeric;
        mode_ff     <= sped_pkg::M_ENTRY;
        if (overflow)
        begin
          lines_ff    <= lines_ff + 10'h0_01;
          cur_line_ff <= lines_ff + 10'h0_01;
        end
      end
      else if (close_line)
      begin
        lines_ff    <= lines_ff + 10'h0_01;
        cur_line_ff <= lines_ff + 10'h0_01;
        chars_ff    <= 6'h0_0;
      end
      if (wipe)
      begin
        wr_ptr_ff   <= 10'h0_00;
        lines_ff    <= 10'h0_00;
        cur_line_ff <= 10'h0_00;
        chars_ff    <= 6'h0_0;
        lbl_vld_ff  <= '0;
        confirm_ff  <= 1'b0;
        mode_ff     <= sped_pkg::M_EDIT;
      end
      else if (confirm_ff && c_vld)
        confirm_ff <= 1'b0;
      else if (is_erase && in_program_entry_command)
      begin
        confirm_ff <= 1'b1;
        mode_ff    <= sped_pkg::M_EDIT;
      end
      else if (in_program_entry_command && !store)
      begin
        if (is_exec)
          mode_ff <= sped_pkg::M_IDLE;
        else if (is_next || is_eline || is_program_entry_command)
        begin
          mode_ff <= sped_pkg::M_EDIT;
          if (is_next && !close_line && (cur_line_ff < lines_ff))
            cur_line_ff <= cur_line_ff + 10'h0_01;
        end
      end
      else if (mode_ff == sped_pkg::M_IDLE)
      begin
        if (is_program_entry_command)
        begin
          mode_ff     <= sped_pkg::M_EDIT;
          cur_line_ff <= lines_ff;
        end
        else if (is_run && (wr_ptr_ff != 10'h0_00))
          mode_ff <= sped_pkg::M_RUN;
      end
      else if (halt_now)
        mode_ff <= sped_pkg::M_IDLE;
    end
  end

  // sequencer: one stored command per clock
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pc_ff         <= 10'h0_00;
      exec_line_ff  <= 10'h0_00;
      skip_ff       <= 1'b0;
      step_ff       <= 1'b0;
      exec_valid_ff <= 1'b0;
      exec_cmd_ff   <= '0;
      halt_shown_ff <= 1'b0;
      halt_line_ff  <= 10'h0_00;
    end
    else
    begin
      exec_valid_ff <= run_state && !at_end && !skip_ff && !is_stop;
      exec_cmd_ff   <= rd;
      if ((mode_ff == sped_pkg::M_IDLE) && is_run)
      begin
        pc_ff         <= 10'h0_00;
        exec_line_ff  <= 10'h0_00;
        skip_ff       <= 1'b0;
        step_ff       <= (c_kind == sped_pkg::K_STEP);
        halt_shown_ff <= 1'b0;
      end
      else if (run_state && !at_end && !is_stop)
      begin
        pc_ff <= pc_ff + 10'h0_01;
        if (eol_ff[pc_ff])
        begin
          exec_line_ff <= exec_line_ff + 10'h0_01;
          skip_ff      <= 1'b0;
        end
        else if (cmp_false)
          skip_ff <= 1'b1;
      end
      if (rd_stop)
      begin
        halt_shown_ff <= 1'b1;
        halt_line_ff  <= exec_line_ff;
      end
      else if (is_program_entry_command)
        halt_shown_ff <= 1'b0;
    end
  end

  assign label_found_o      = (label_query_i < `NUM_LABELS) && lbl_vld_ff[label_query_i];
  assign label_line_o       = label_found_o ? lbl_line_ff[label_query_i] : 10'h0_00;
  assign mode_o             = mode_ff;
  assign program_display_o  = in_program_entry_command && !confirm_ff;
  assign display_mode_o     = crt_mode_i;
  assign prompt_row_o       = `PROMPT_ROW;
  assign show_line_number_o = (mode_ff == sped_pkg::M_EDIT) && !confirm_ff;
  assign cur_line_o         = cur_line_ff;
  assign line_count_o       = lines_ff;
  assign line_chars_o       = chars_ff;
  assign confirm_prompt_o   = confirm_ff;
  assign warning_o          = warning_ff;
  assign clear_error_o      = clr_err_ff;
  assign busy_o             = run_state;
  assign exec_valid_o       = exec_valid_ff;
  assign exec_cmd_o         = exec_cmd_ff;
  assign halt_shown_o       = halt_shown_ff;
  assign halt_line_o        = halt_line_ff;
  assign halt_row_o         = `HALT_ROW;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_erase_req;
    is_erase && in_program_entry_command && !confirm_ff;
  endsequence
  sequence s_abort;
    c_vld && !is_next;
  endsequence

  a_exec_to_idle: assert property (in_program_entry_command && is_exec && !confirm_ff && !store
    |=> mode_ff == sped_pkg::M_IDLE) else $error("execute did not return to idle");
  a_key_alternate: assert property (key_i && !cmd_i.valid && mode_ff == sped_pkg::M_IDLE
    |=> mode_ff == sped_pkg::M_EDIT) else $error("key did not enter program edit");
  a_next_numbers: assert property (close_line && is_next
    |=> lines_ff == $past(lines_ff) + 10'h0_01 && chars_ff == 6'h0_0)
    else $error("next-line did not number the line");
  a_wrap_warning: assert property (store && overflow
    |=> warning_o && chars_ff == $past(cmd_i.len) ##1 (!warning_o || $past(store && overflow)))
    else $error("line wrap not flagged once");
  a_busy_run: assert property ($rose(busy_o)
    |-> pc_ff == 10'h0_00 && exec_line_ff == 10'h0_00) else $error("run not started at line zero");
  a_busy_held: assert property (run_state && !halt_now
    |=> busy_o) else $error("busy dropped during run");
  a_stop_halt_line: assert property (rd_stop
    |=> halt_shown_o && halt_line_o == $past(exec_line_ff) && mode_ff == sped_pkg::M_IDLE)
    else $error("stored stop line not shown");
  a_erase_confirm: assert property (s_erase_req |=> confirm_prompt_o && !program_display_o
    && !show_line_number_o) else $error("erase confirmation prompt missing");
  a_erase_abort: assert property (confirm_ff ##0 s_abort
    |=> !confirm_ff && wr_ptr_ff == $past(wr_ptr_ff)) else $error("aborted erase changed memory");
  a_erase_error: assert property (is_erase && !in_program_entry_command && !run_state
    |=> clear_error_o ##1 (!clear_error_o || $past(is_erase && !in_program_entry_command && !run_state)))
    else $error("erase error not reported");
  a_wipe_edit: assert property (wipe
    |=> mode_ff == sped_pkg::M_EDIT && lines_ff == 10'h0_00 && wr_ptr_ff == 10'h0_00)
    else $error("confirmed erase left program");
endmodule // stored_program_entry_editor

//--- operator_keyboard.sv
`timescale 1ns/1ps
module operator_keyboard (
  // clock
  input  wire logic      clock_i,
  // towards the block
  output sped_pkg::cmd_s cmd_o,
  output logic           key_o
);
  initial
  begin
    cmd_o = '0;
    key_o = 1'b0;
  end
  // released fields show the inverse, never the stale command
  task automatic issue(input sped_pkg::kind_e kind, input logic numeric,
                       input logic [5:0] len, input logic [6:0] label);
    @(posedge clock_i);
    #1;
    cmd_o = {1'b1, kind, numeric, len, {2'b00, len}, label};
    @(posedge clock_i);
    #1;
    cmd_o = {1'b0, ~cmd_o[25:0]};
  endtask
  task automatic press();
    @(posedge clock_i);
    #1;
    key_o = 1'b1;
    @(posedge clock_i);
    #1;
    key_o = 1'b0;
  endtask
  // routine opened by a label alone on its line
  task automatic open_routine(input logic [6:0] label);
    issue(sped_pkg::K_LABEL, 1'b0, 6'h03, label);
    issue(sped_pkg::K_NEXT, 1'b0, 6'h00, 7'h00);
  endtask
endmodule // operator_keyboard

//--- stored_program_entry_editor_tb_top.sv
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module stored_program_entry_editor_tb_top;
  logic clock_i, arst_n_i, key_i, yx_greater_i, label_found_o, program_display_o;
  logic show_line_number_o, confirm_prompt_o, warning_o, clear_error_o, busy_o;
  logic exec_valid_o, halt_shown_o;
  logic [3:0] crt_mode_i, display_mode_o;
  logic [6:0] label_query_i;
  logic [9:0] label_line_o, cur_line_o, line_count_o, halt_line_o;
  logic [5:0] line_chars_o;
  logic [4:0] prompt_row_o, halt_row_o;
  sped_pkg::cmd_s    cmd_i;
  sped_pkg::mode_e   mode_o;
  sped_pkg::stored_s exec_cmd_o;
  int err_count = 0;
  int tests_run = 0;
  operator_keyboard operator_keyboard_inst (.clock_i(clock_i), .cmd_o(cmd_i), .key_o(key_i));
  stored_program_entry_editor stored_program_entry_editor_inst (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .cmd_i(cmd_i), .key_i(key_i),
    .yx_greater_i(yx_greater_i), .crt_mode_i(crt_mode_i), .label_query_i(label_query_i),
    .label_found_o(label_found_o), .label_line_o(label_line_o), .mode_o(mode_o),
    .program_display_o(program_display_o), .display_mode_o(display_mode_o),
    .prompt_row_o(prompt_row_o), .show_line_number_o(show_line_number_o),
    .cur_line_o(cur_line_o), .line_count_o(line_count_o), .line_chars_o(line_chars_o),
    .confirm_prompt_o(confirm_prompt_o), .warning_o(warning_o),
    .clear_error_o(clear_error_o), .busy_o(busy_o), .exec_valid_o(exec_valid_o),
    .exec_cmd_o(exec_cmd_o), .halt_shown_o(halt_shown_o), .halt_line_o(halt_line_o),
    .halt_row_o(halt_row_o));
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic cmd(input sped_pkg::kind_e k, input logic n, input logic [5:0] len,
                     input logic [6:0] label_reference_command);
    operator_keyboard_inst.issue(k, n, len, label_reference_command);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic entry_walk();
    operator_keyboard_inst.press();
    `CHECK("mode", sped_pkg::M_EDIT, mode_o)
    `CHECK("prompt_row", 5'h08, prompt_row_o)
    `CHECK("program_display", 1'b1, program_display_o)
    cmd(sped_pkg::K_LABEL, 1'b0, 6'h03, 7'h05);
    `CHECK("mode", sped_pkg::M_ENTRY, mode_o)
    `CHECK("show_line_number", 1'b0, show_line_number_o)
    cmd(sped_pkg::K_OTHER, 1'b1, 6'h01, 7'h00);
    `CHECK("chars", 6'h05, line_chars_o)
    cmd(sped_pkg::K_OTHER, 1'b1, 6'h01, 7'h00);
    `CHECK("chars", 6'h06, line_chars_o)
    cmd(sped_pkg::K_NEXT, 1'b0, 6'h00, 7'h00);
    `CHECK("lines", 10'h001, line_count_o)
    `CHECK("cur_line", 10'h001, cur_line_o)
    `CHECK("chars", 6'h00, line_chars_o)
    `CHECK("mode", sped_pkg::M_EDIT, mode_o)
  endtask
  task automatic wrap_and_labels();
    repeat (3) cmd(sped_pkg::K_OTHER, 1'b0, 6'h0a, 7'h00);
    `CHECK("chars", 6'h20, line_chars_o)
    cmd(sped_pkg::K_LABEL, 1'b0, 6'h02, 7'h05);
    `CHECK("chars at limit", 6'h23, line_chars_o)
    `CHECK("warning", 1'b0, warning_o)
    cmd(sped_pkg::K_OTHER, 1'b0, 6'h01, 7'h00);
    `CHECK("warning", 1'b1, warning_o)
    `CHECK("lines", 10'h002, line_count_o)
    `CHECK("chars", 6'h01, line_chars_o)
    cmd(sped_pkg::K_NEXT, 1'b0, 6'h00, 7'h00);
    cmd(sped_pkg::K_LABEL, 1'b0, 6'h03, 7'h63);
    cmd(sped_pkg::K_STOP, 1'b0, 6'h04, 7'h00);
    cmd(sped_pkg::K_NEXT, 1'b0, 6'h00, 7'h00);
    `CHECK("lines", 10'h004, line_count_o)
    label_query_i = 7'h05;
    #1;
    `CHECK("first label", 1'b1, label_found_o)
    `CHECK("first label line", 10'h000, label_line_o)
    label_query_i = 7'h63;
    #1;
    `CHECK("label 99 line", 10'h003, label_line_o)
    label_query_i = 7'h06;
    #1;
    `CHECK("absent label", 1'b0, label_found_o)
  endtask
  task automatic run_to_halt();
    int   n;
    logic dark;
    n = 0;
    dark = 1'b0;
    cmd(sped_pkg::K_EXECUTE, 1'b0, 6'h00, 7'h00);
    `CHECK("mode", sped_pkg::M_IDLE, mode_o)
    `CHECK("program_display", 1'b0, program_display_o)
    `CHECK("display_mode", 4'h5, display_mode_o)
    cmd(sped_pkg::K_RUN, 1'b0, 6'h00, 7'h00);
    for (int i = 0; i < 200 && halt_shown_o !== 1'b1; i++)
    begin
      dark = dark | (busy_o !== 1'b1);
      @(posedge clock_i);
      #1;
      if (exec_valid_o === 1'b1 && n == 0)
        `CHECK("first exec", 7'h05, exec_cmd_o.label)
      if (exec_valid_o === 1'b1)
        n++;
    end
    if (halt_shown_o !== 1'b1)
    begin
      err_count++;
      complete_run();
    end
    `CHECK("busy lit", 1'b0, dark)
    `CHECK("all executed", 32'd10, n)
    `CHECK("halt line", 10'h003, halt_line_o)
    `CHECK("halt row", 5'h10, halt_row_o)
    `CHECK("busy", 1'b0, busy_o)
  endtask
  task automatic direct_stop();
    cmd(sped_pkg::K_RUN, 1'b0, 6'h00, 7'h00);
    cmd(sped_pkg::K_OTHER, 1'b0, 6'h03, 7'h00);
    `CHECK("still running", sped_pkg::M_RUN, mode_o)
    cmd(sped_pkg::K_STOP, 1'b0, 6'h04, 7'h00);
    `CHECK("stopped", sped_pkg::M_IDLE, mode_o)
    `CHECK("busy", 1'b0, busy_o)
  endtask
  task automatic erase_program();
    cmd(sped_pkg::K_ERASE_ALL, 1'b0, 6'h03, 7'h00);
    `CHECK("clear error", 1'b1, clear_error_o)
    operator_keyboard_inst.press();
    `CHECK("mode", sped_pkg::M_EDIT, mode_o)
    cmd(sped_pkg::K_ERASE_ALL, 1'b0, 6'h03, 7'h00);
    `CHECK("confirm", 1'b1, confirm_prompt_o)
    `CHECK("show_line_number", 1'b0, show_line_number_o)
    `CHECK("program_display", 1'b0, program_display_o)
    cmd(sped_pkg::K_OTHER, 1'b0, 6'h03, 7'h00);
    `CHECK("confirm", 1'b0, confirm_prompt_o)
    `CHECK("lines kept", 10'h004, line_count_o)
    cmd(sped_pkg::K_ERASE_ALL, 1'b0, 6'h03, 7'h00);
    cmd(sped_pkg::K_NEXT, 1'b0, 6'h00, 7'h00);
    `CHECK("lines", 10'h000, line_count_o)
    `CHECK("mode", sped_pkg::M_EDIT, mode_o)
    label_query_i = 7'h05;
    #1;
    `CHECK("label gone", 1'b0, label_found_o)
    operator_keyboard_inst.press();
    `CHECK("mode", sped_pkg::M_IDLE, mode_o)
    cmd(sped_pkg::K_RUN, 1'b0, 6'h00, 7'h00);
    `CHECK("empty run refused", 1'b0, busy_o)
  endtask
  task automatic branch_and_step();
    int   n;
    logic seen_skip;
    n = 0;
    seen_skip = 1'b0;
    operator_keyboard_inst.press();
    operator_keyboard_inst.open_routine(7'h07);
    cmd(sped_pkg::K_COMPARE, 1'b0, 6'h05, 7'h00);
    cmd(sped_pkg::K_OTHER, 1'b0, 6'h03, 7'h11);
    cmd(sped_pkg::K_NEXT, 1'b0, 6'h00, 7'h00);
    cmd(sped_pkg::K_OTHER, 1'b0, 6'h03, 7'h22);
    cmd(sped_pkg::K_STOP, 1'b0, 6'h04, 7'h00);
    cmd(sped_pkg::K_ERASE_LINE, 1'b0, 6'h03, 7'h00);
    `CHECK("lines", 10'h003, line_count_o)
    `CHECK("mode", sped_pkg::M_EDIT, mode_o)
    label_query_i = 7'h07;
    #1;
    `CHECK("routine label line", 10'h000, label_line_o)
    operator_keyboard_inst.press();
    `CHECK("mode", sped_pkg::M_IDLE, mode_o)
    yx_greater_i = 1'b0;
    cmd(sped_pkg::K_RUN, 1'b0, 6'h00, 7'h00);
    for (int i = 0; i < 50 && halt_shown_o !== 1'b1; i++)
    begin
      @(posedge clock_i);
      #1;
      if (exec_valid_o === 1'b1)
        n++;
      if (exec_valid_o === 1'b1 && exec_cmd_o.label === 7'h11)
        seen_skip = 1'b1;
    end
    if (halt_shown_o !== 1'b1)
    begin
      err_count++;
      complete_run();
    end
    `CHECK("executed", 32'd4, n)
    `CHECK("rest of line skipped", 1'b0, seen_skip)
    `CHECK("halt line", 10'h002, halt_line_o)
    yx_greater_i = 1'b1;
    cmd(sped_pkg::K_STEP, 1'b0, 6'h00, 7'h00);
    `CHECK("step busy", 1'b1, busy_o)
    @(posedge clock_i);
    #1;
    `CHECK("step exec", 1'b1, exec_valid_o)
    `CHECK("step cmd", 7'h07, exec_cmd_o.label)
    `CHECK("step done", 1'b0, busy_o)
  endtask
  initial
  begin
    arst_n_i = 1'b0;
    yx_greater_i = 1'b1;
    crt_mode_i = 4'h5;
    label_query_i = 7'h00;
    repeat (16) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    entry_walk();
    wrap_and_labels();
    run_to_halt();
    direct_stop();
    erase_program();
    branch_and_step();
    complete_run();
  end
endmodule // stored_program_entry_editor_tb_top
